// >>> design/srel_top.sv
// Two-channel safety relay evaluation logic with Wishbone registers
// Notes on behaviour
// - Test outputs carry distinct pulse patterns
// - Foreign pulse on an input flags cross-circuit
// - Cross-circuit checking can be switched off
// - Trip or fault opens every enabling output
// - Relay variant: signaling output closes on trip
// - Semiconductor variant: signaling output opens on trip
// - No enable unless feedback loop closed
// - Delayed output drops a delay after trip
// - Supply loss drops delayed output at once
// - Auto start after input check and self-test
// - Manual start on START rising edge
// - Monitored start needs press and release
// - START held over 2 s enters fault
// - Start mode resets to monitored
// - Synchronism: both close within 0.5 s
// - Synchronism off by default, needs combination
// - Start-up test needs sensor open then close
// - Start-up test off by default
// - Fault memory is volatile, lost at reset
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "srel_defs.svh"
module srel_top #(
  parameter logic [25:0] START_CYC = 26'(`SREL_START_CYC),
  parameter logic [25:0] SYNC_CYC  = 26'(`SREL_SYNC_CYC),
  parameter logic [25:0] DLY_CYC   = 26'(`SREL_DLY_CYC)
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sens1_i,
  input  wire logic        sens2_i,
  input  wire logic        start_i,
  input  wire logic        feedback_i,
  input  wire logic        supply_fail_i,
  output logic             test1_o,
  output logic             test2_o,
  output logic             en_inst_o,
  output logic             en_dly_o,
  output logic             signal_o,
  output logic             lamp_device_o,
  output logic             fault_indicator_lamp_o,
  output logic             lamp_enable_o,
  output logic             lamp_sensor_o
);
  import srel_pkg::*;

  logic [4:0]  pins_s;        // Synchronised pins
  logic        s1_s, s2_s, st_s, fb_s, pf_s;
  srel_mode_t  mode_r;        // Start mode
  logic        cross_en_r;    // Cross-circuit check on
  logic        sync_en_r;     // Synchronism check requested
  logic        stt_en_r;      // Start-up test on
  logic        semi_r;        // Semiconductor output variant
  logic        clr_r;         // Fault clear pulse from software
  srel_state_t st_r;          // Evaluation state
  logic [7:0]  slot_cnt_r;    // Cycles within a test slot
  logic [1:0]  slot_r;        // Test slot index
  logic        tick;          // End of a test slot
  logic        ch1_r, ch2_r;  // Channel closed as sampled
  logic        cross_hit;     // Foreign level seen on an input
  logic        cross_flt_r;   // Sticky cross-circuit fault
  logic        start_flt_r;   // Sticky START stuck fault
  logic [25:0] start_cnt_r;   // START held time
  logic        start_prev_r;  // START one cycle ago
  logic        start_rise, start_fall;
  logic        armed_r;       // Monitored start press seen
  logic [25:0] sync_cnt_r;    // Time one channel alone is closed
  logic        sync_bad_r;    // Synchronism missed
  logic        sync_act;      // Synchronism check in force
  logic        seen_open_r;   // Sensor opened since reset
  logic [7:0]  self_cnt_r;    // Self-test timer
  logic        ready;         // Inputs allow a start
  logic        go;            // Selected start condition met
  logic        trip;          // Either channel opened in run
  logic        imm_off;       // Drop delayed output at once
  logic [25:0] dly_cnt_r;     // Delay left on delayed output
  logic [22:0] blink_r;       // Lamp flash divider
  logic        wb_hit;        // New bus request this cycle

  // Pins pass two flip-flops before any logic reads them
  srel_sync #(.W(5)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({supply_fail_i, feedback_i, start_i, sens2_i, sens1_i}),
    .q_o    (pins_s)
  );
  assign {pf_s, fb_s, st_s, s2_s, s1_s} = pins_s;

  // Bus request is taken once; ack drops the cycle after it was given
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Control register writes; fault clear is a one-cycle pulse
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r     <= srel_mode_t'(`SREL_MODE_RST);
      cross_en_r <= `SREL_CROSS_RST;
      sync_en_r  <= `SREL_SYNC_RST;
      stt_en_r   <= `SREL_STT_RST;
      semi_r     <= `SREL_SEMI_RST;
      clr_r      <= 1'b0;
    end else begin
      clr_r <= 1'b0;
      // Writes land at the edge where the master samples ack, never earlier
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `SREL_CTRL_OFS) begin
        mode_r     <= srel_mode_t'(wb_dat_i[`SREL_MODE_MSB:`SREL_MODE_LSB]);
        cross_en_r <= wb_dat_i[`SREL_CROSS_BIT];
        sync_en_r  <= wb_dat_i[`SREL_SYNC_BIT];
        stt_en_r   <= wb_dat_i[`SREL_STT_BIT];
        semi_r     <= wb_dat_i[`SREL_SEMI_BIT];
        clr_r      <= wb_dat_i[`SREL_CLR_BIT];
      end
    end
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `SREL_CTRL_OFS: wb_dat_o <= {26'h0, semi_r, stt_en_r, sync_en_r,
                                       cross_en_r, mode_r};
          `SREL_STAT_OFS: wb_dat_o <= {22'h0, sync_bad_r, en_dly_o, en_inst_o,
                                       start_flt_r, cross_flt_r, fb_s, ch2_r,
                                       ch1_r, st_r};
          default:        wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Slot divider: one enable pulse per test slot
  assign tick = (slot_cnt_r == `SREL_SLOT_CYC - 8'h01);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_cnt_r <= 8'h0;
      slot_r     <= 2'h0;
    end else if (tick) begin
      slot_cnt_r <= 8'h0;
      slot_r     <= slot_r + 2'h1;
    end else begin
      slot_cnt_r <= slot_cnt_r + 8'h01;
    end
  end

  // Test 1 is low in slot 1, test 2 in slot 3, never together
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      test1_o <= 1'b1;
      test2_o <= 1'b1;
    end else begin
      test1_o <= !(cross_en_r && slot_r == 2'h1);
      test2_o <= !(cross_en_r && slot_r == 2'h3);
    end
  end

  // A contact passes its own test level; high during its low slot is foreign
  assign cross_hit = cross_en_r && tick &&
                     ((!test1_o && s1_s) || (!test2_o && s2_s));

  // Channels are sampled at slot end, or every cycle with the check off, only while their own test is high
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ch1_r <= 1'b0;
      ch2_r <= 1'b0;
    end else if (tick || !cross_en_r) begin
      if (test1_o) ch1_r <= s1_s;
      if (test2_o) ch2_r <= s2_s;
    end
  end

  // START edges and held-time counter, saturating at the limit
  assign start_rise = st_s && !start_prev_r;
  assign start_fall = !st_s && start_prev_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_prev_r <= 1'b0;
      start_cnt_r  <= 26'h0;
    end else begin
      start_prev_r <= st_s;
      if (!st_s) start_cnt_r <= 26'h0;
      else if (start_cnt_r != START_CYC) start_cnt_r <= start_cnt_r + 26'h1;
    end
  end

  // Sticky faults live in flip-flops only and vanish at power loss
  // A new fault in the clear cycle wins over the clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cross_flt_r <= 1'b0;
      start_flt_r <= 1'b0;
    end else begin
      if (cross_hit) cross_flt_r <= 1'b1;
      else if (clr_r) cross_flt_r <= 1'b0;
      if (start_cnt_r == START_CYC) start_flt_r <= 1'b1;
      else if (clr_r) start_flt_r <= 1'b0;
    end
  end

  // Synchronism only with auto start, checking the closing skew
  assign sync_act = sync_en_r && mode_r == SREL_AUTO;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_cnt_r <= 26'h0;
      sync_bad_r <= 1'b0;
    end else if (!ch1_r && !ch2_r) begin
      sync_cnt_r <= 26'h0;
      sync_bad_r <= 1'b0;
    end else if (ch1_r != ch2_r) begin
      if (sync_cnt_r != SYNC_CYC) sync_cnt_r <= sync_cnt_r + 26'h1;
      else sync_bad_r <= 1'b1;
    end
  end

  // Start-up test: remember one opening of the sensor since reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) seen_open_r <= 1'b0;
    // Only a real sample counts; the reset value of the channels is no opening
    else if ((tick || !cross_en_r) && ((test1_o && !s1_s) || (test2_o && !s2_s)))
      seen_open_r <= 1'b1;
  end

  // Inputs checked, feedback closed, options satisfied
  assign ready = ch1_r && ch2_r && fb_s
                 && (!stt_en_r || seen_open_r)
                 && !(sync_act && sync_bad_r);

  // Start condition of the selected mode
  always_comb begin
    case (mode_r)
      SREL_AUTO:      go = 1'b1;
      SREL_MANUAL:    go = start_rise;
      SREL_MONITORED: go = start_fall && armed_r;
      default:        go = 1'b0;
    endcase
  end

  // Monitored start: press must happen while waiting and ready
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) armed_r <= 1'b0;
    else if (st_r != SREL_WAIT || !ready) armed_r <= 1'b0;
    else if (start_rise) armed_r <= 1'b1;
  end

  assign trip    = !ch1_r || !ch2_r;
  assign imm_off = pf_s || st_r == SREL_FAULT;

  // Main state machine and instantaneous enable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r       <= SREL_INIT;
      self_cnt_r <= 8'h0;
      en_inst_o  <= 1'b0;
    end else begin
      case (st_r)
        SREL_INIT: begin
          // Self-test window before any start is allowed
          self_cnt_r <= self_cnt_r + 8'h01;
          if (cross_flt_r || start_flt_r) st_r <= SREL_FAULT;
          else if (self_cnt_r == `SREL_SELFTEST_CYC) st_r <= SREL_WAIT;
        end
        SREL_WAIT: begin
          if (cross_flt_r || start_flt_r) st_r <= SREL_FAULT;
          else if (ready && go) begin
            st_r      <= SREL_RUN;
            en_inst_o <= 1'b1;
          end
        end
        SREL_RUN: begin
          if (cross_flt_r || start_flt_r || pf_s) begin
            st_r      <= SREL_FAULT;
            en_inst_o <= 1'b0;
          end else if (trip) begin
            st_r      <= SREL_WAIT;
            en_inst_o <= 1'b0;
          end
        end
        SREL_FAULT: begin
          // Leave only when cleared with faults gone and START released
          en_inst_o <= 1'b0;
          // A stuck-START flag raised in the clear cycle keeps the fault
          if (clr_r && !cross_hit && !st_s && start_cnt_r != START_CYC) st_r <= SREL_WAIT;
        end
        default: begin
          st_r      <= SREL_FAULT;
          en_inst_o <= 1'b0;
        end
      endcase
    end
  end

  // Delayed output follows the trip after the delay, unless forced off
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      en_dly_o  <= 1'b0;
      dly_cnt_r <= 26'h0;
    end else if (imm_off) begin
      en_dly_o  <= 1'b0;
      dly_cnt_r <= 26'h0;
    end else if (en_inst_o) begin
      en_dly_o  <= 1'b1;
      dly_cnt_r <= DLY_CYC;
    end else if (dly_cnt_r != 26'h0) begin
      dly_cnt_r <= dly_cnt_r - 26'h1;
    end else begin
      en_dly_o  <= 1'b0;
    end
  end

  // Signaling output polarity depends on output variant
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) signal_o <= !`SREL_SEMI_RST;
    else if (semi_r) signal_o <= (st_r == SREL_RUN);
    else signal_o <= (st_r != SREL_RUN);
  end

  // Lamps; fault pattern is device on, fault and enable flashing, sensor off
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_r                <= 23'h0;
      lamp_device_o          <= 1'b0;
      fault_indicator_lamp_o <= 1'b0;
      lamp_enable_o          <= 1'b0;
      lamp_sensor_o          <= 1'b0;
    end else begin
      blink_r       <= blink_r + 23'h1;
      lamp_device_o <= 1'b1;
      if (st_r == SREL_FAULT) begin
        fault_indicator_lamp_o <= blink_r[`SREL_BLINK_BIT];
        lamp_enable_o          <= blink_r[`SREL_BLINK_BIT];
        lamp_sensor_o          <= 1'b0;
      end else begin
        fault_indicator_lamp_o <= 1'b0;
        lamp_enable_o          <= en_inst_o;
        lamp_sensor_o          <= ch1_r && ch2_r;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Monitored start: a press then a release of START
  sequence s_press;
    start_rise;
  endsequence
  sequence s_release;
    start_fall;
  endsequence

  a_tests_distinct: assert property (test1_o || test2_o)
    else $error("both test outputs low together");
  a_cross_faults: assert property (cross_hit |=> cross_flt_r ##1 st_r == SREL_FAULT)
    else $error("cross-circuit not flagged");
  a_cross_off_quiet: assert property (!cross_en_r |=> test1_o && test2_o)
    else $error("test pulses while check off");
  a_fault_opens: assert property (st_r == SREL_FAULT |=> !en_inst_o && !en_dly_o)
    else $error("enable output on in fault");
  a_relay_signal: assert property (!semi_r && st_r != SREL_RUN |=> signal_o)
    else $error("relay signaling not closed");
  a_semi_signal: assert property (semi_r && st_r != SREL_RUN |=> !signal_o)
    else $error("semiconductor signaling not open");
  a_feedback_gate: assert property ($rose(en_inst_o) |-> $past(fb_s))
    else $error("enabled with feedback open");
  a_delay_holds: assert property (
    $fell(en_inst_o) && !imm_off && DLY_CYC > 26'h1 |-> en_dly_o)
    else $error("delayed output dropped early");
  a_supply_drop: assert property (pf_s |=> !en_dly_o)
    else $error("delayed output held on supply loss");
  a_start_stuck: assert property (
    start_cnt_r == START_CYC |=> start_flt_r ##1 st_r == SREL_FAULT)
    else $error("stuck START not faulted");
  a_monitored_start: assert property (
    st_r == SREL_WAIT && mode_r == SREL_MONITORED ##0 s_press ##1
    (!start_fall && mode_r == SREL_MONITORED)[*1] |=> st_r != SREL_RUN)
    else $error("monitored start without release");
  a_run_release: assert property (
    mode_r == SREL_MONITORED && st_r == SREL_WAIT && ready && armed_r ##0 s_release
    |=> st_r == SREL_RUN || cross_flt_r || start_flt_r)
    else $error("monitored release did not start");
  a_trip_channel: assert property (st_r == SREL_RUN && trip |=> !en_inst_o)
    else $error("channel open did not trip");
  a_startup_test: assert property (
    stt_en_r && !seen_open_r && st_r == SREL_WAIT |=> st_r != SREL_RUN)
    else $error("start before start-up test");
endmodule

// >>> pkg/srel_defs.svh
// Constants of the safety relay evaluation logic: offsets, fields, resets, timing
`ifndef SREL_DEFS_SVH
`define SREL_DEFS_SVH

// Register byte offsets
`define SREL_CTRL_OFS     8'h00
`define SREL_STAT_OFS     8'h04

// Control register fields
`define SREL_MODE_LSB     0
`define SREL_MODE_MSB     1
`define SREL_CROSS_BIT    2
`define SREL_SYNC_BIT     3
`define SREL_STT_BIT      4
`define SREL_SEMI_BIT     5
`define SREL_CLR_BIT      6

// Control reset values
`define SREL_MODE_RST     2'h2
`define SREL_CROSS_RST    1'h1
`define SREL_SYNC_RST     1'h0
`define SREL_STT_RST      1'h0
`define SREL_SEMI_RST     1'h0

// Clock rate and times
`define SREL_CLK_KHZ      20000
`define SREL_START_MS     2000
`define SREL_SYNC_MS      500
`define SREL_DLY_MS       1000
`define SREL_START_CYC    (`SREL_START_MS * `SREL_CLK_KHZ)
`define SREL_SYNC_CYC     (`SREL_SYNC_MS * `SREL_CLK_KHZ)
`define SREL_DLY_CYC      (`SREL_DLY_MS * `SREL_CLK_KHZ)
`define SREL_SLOT_CYC     8'h64
`define SREL_SELFTEST_CYC 8'h10
`define SREL_BLINK_BIT    22

`endif

// >>> pkg/srel_pkg.sv
// Types of the safety relay evaluation logic
package srel_pkg;
  // Start modes as coded in the control register
  typedef enum logic [1:0] {
    SREL_AUTO,
    SREL_MANUAL,
    SREL_MONITORED,
    SREL_MODE_RSVD
  } srel_mode_t;

  // Main evaluation states
  typedef enum logic [1:0] {
    SREL_INIT,
    SREL_WAIT,
    SREL_RUN,
    SREL_FAULT
  } srel_state_t;
endpackage

// >>> design/srel_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module srel_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;  // First stage, read only by the second

  // Both stages reset to the open, inactive level
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// >>> testbench/srel_contacts.sv
// Behavioural model of the two sensor contacts fed by the test outputs
`timescale 1ns/1ps
module srel_contacts (
  input  wire logic test1_i,  // Test signal for channel 1
  input  wire logic test2_i,  // Test signal for channel 2
  input  wire logic close1_i, // Contact 1 closed
  input  wire logic close2_i, // Contact 2 closed
  input  wire logic short_i,  // Squashed cable feeds test 1 into channel 2
  output logic      sens1_o,  // Channel 1 input of the relay
  output logic      sens2_o   // Channel 2 input of the relay
);
  // Normally-open contacts: an open one passes no test signal, the pin pulls low
  assign sens1_o = close1_i & test1_i;
  // A cross-circuit shows the foreign pulse pattern on channel 2
  assign sens2_o = short_i ? test1_i : (close2_i & test2_i);
endmodule

// >>> testbench/srel_top_test.sv
// Self-checking bench of the safety relay evaluation logic
`timescale 1ns/1ps
module srel_top_test;
  logic        mclk_i, rst_i;                 // Clock and reset
  logic        wb_cyc, wb_stb, wb_we;         // Bus request
  logic [7:0]  wb_adr;                        // Bus address
  logic [3:0]  wb_sel;                        // Byte enables
  logic [31:0] wb_dat, wb_rdat, rv;           // Write data, read data, last read
  logic        wb_ack;                        // Bus answer
  logic        sens1, sens2, start, feedback, supply_fail; // Field inputs
  logic        close1, close2, short_c;       // Contact states driven by scenarios
  logic        test1, test2, en_inst, en_dly, signal; // Relay outputs
  logic        lamp_dev, lamp_fault, lamp_en, lamp_sens; // Lamps
  int          mismatches, check_count, cycles; // Report counters

  // Short counts keep the run brief; expectations below follow these values
  // Sync limit sits above the 100-cycle sampling skew of the two channels
  srel_top #(.START_CYC(26'd200), .SYNC_CYC(26'd150), .DLY_CYC(26'd20)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sens1_i(sens1), .sens2_i(sens2),
    .start_i(start), .feedback_i(feedback), .supply_fail_i(supply_fail),
    .test1_o(test1), .test2_o(test2), .en_inst_o(en_inst), .en_dly_o(en_dly),
    .signal_o(signal), .lamp_device_o(lamp_dev), .fault_indicator_lamp_o(lamp_fault),
    .lamp_enable_o(lamp_en), .lamp_sensor_o(lamp_sens));

  srel_contacts far (.test1_i(test1), .test2_i(test2), .close1_i(close1),
    .close2_i(close2), .short_i(short_c), .sens1_o(sens1), .sens2_o(sens2));

  // Free-running 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Hang guard: the tests need about 11000 cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; the request holds until ack is seen at a rising edge
  // Only the hang guard ends a wait for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge mclk_i);
    end while (wb_ack !== 1'b1);
    rv = wb_rdat;
    chk("wb_ack", 32'h1, {31'h0, wb_ack});
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Checks land on falling edges, away from the design's updates
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic wait_en(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (en_inst !== v && n < lim);
    chk("en_inst_o", {31'h0, v}, {31'h0, en_inst});
  endtask

  task automatic t_reset();
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl_reset", 32'h6, rv);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rv);
    idle(1);
    chk("signal_o", 32'h1, {31'h0, signal});
    chk("en_inst_o", 32'h0, {31'h0, en_inst});
    $display("test reset done");
  endtask

  // Test outputs pulse low, never at the same time
  task automatic t_pulses();
    int l1, l2, ov;
    {l1, l2, ov} = '0;
    repeat (800) begin
      @(negedge mclk_i);
      l1 += !test1;
      l2 += !test2;
      ov += !test1 && !test2;
    end
    chk("pulses", 32'h1, {31'h0, l1 > 0 && l2 > 0 && ov == 0});
    $display("test pulses done");
  endtask

  task automatic t_monitored();
    @(posedge mclk_i) close1 <= 1'b1;
    @(posedge mclk_i) close2 <= 1'b1;
    idle(900);
    @(posedge mclk_i) start <= 1'b1;
    idle(20);
    chk("held_start", 32'h0, {31'h0, en_inst});
    @(posedge mclk_i) start <= 1'b0;
    wait_en(1'b1, 20);
    idle(1);
    chk("lamp_enable", 32'h1, {31'h0, lamp_en});
    chk("lamp_fault", 32'h0, {31'h0, lamp_fault});
    @(posedge mclk_i) close1 <= 1'b0;
    wait_en(1'b0, 600);
    idle(1);
    chk("signal_o", 32'h1, {31'h0, signal});
    idle(10);
    chk("en_dly_o", 32'h1, {31'h0, en_dly});
    idle(15);
    chk("en_dly_o", 32'h0, {31'h0, en_dly});
    $display("test monitored done");
  endtask

  task automatic t_auto();
    wb(1'b1, 8'h00, 32'h4);
    @(posedge mclk_i) feedback <= 1'b0;
    @(posedge mclk_i) close1 <= 1'b1;
    idle(900);
    chk("open_loop", 32'h0, {31'h0, en_inst});
    @(posedge mclk_i) feedback <= 1'b1;
    wait_en(1'b1, 50);
    wb(1'b1, 8'h00, 32'h24);
    idle(3);
    chk("semi_run", 32'h1, {31'h0, signal});
    @(posedge mclk_i) close2 <= 1'b0;
    wait_en(1'b0, 600);
    idle(3);
    chk("semi_trip", 32'h0, {31'h0, signal});
    wb(1'b1, 8'h00, 32'h4);
    @(posedge mclk_i) close2 <= 1'b1;
    wait_en(1'b1, 1000);
    @(posedge mclk_i) supply_fail <= 1'b1;
    idle(4);
    chk("supply_dly", 32'h0, {31'h0, en_dly});
    wb(1'b0, 8'h04, 32'h0);
    chk("supply_state", 32'h3, {30'h0, rv[1:0]});
    @(posedge mclk_i) supply_fail <= 1'b0;
    $display("test auto done");
  endtask

  task automatic t_cross();
    @(posedge mclk_i) rst_i <= 1'b1;
    @(posedge mclk_i) rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk("state_after_reset", 32'h0, {31'h0, rv[1]});
    wb(1'b1, 8'h00, 32'h14);
    idle(900);
    chk("startup_hold", 32'h0, {31'h0, en_inst});
    @(posedge mclk_i) short_c <= 1'b1;
    idle(900);
    wb(1'b0, 8'h04, 32'h0);
    chk("cross_fault", 32'h1, {31'h0, rv[5]});
    chk("en_inst_o", 32'h0, {31'h0, en_inst});
    wb(1'b1, 8'h00, 32'h40);
    wait_en(1'b1, 1000);
    chk("tests_high", 32'h1, {31'h0, test1 & test2});
    wb(1'b0, 8'h04, 32'h0);
    chk("cross_clear", 32'h0, {31'h0, rv[5]});
    @(posedge mclk_i) short_c <= 1'b0;
    $display("test cross done");
  endtask

  task automatic t_start();
    @(posedge mclk_i) start <= 1'b1;
    idle(230);
    wb(1'b0, 8'h04, 32'h0);
    chk("stuck_state", 32'h3, {30'h0, rv[1:0]});
    chk("stuck_flag", 32'h1, {31'h0, rv[6]});
    chk("lamp_device", 32'h1, {31'h0, lamp_dev});
    chk("lamp_sensor", 32'h0, {31'h0, lamp_sens});
    chk("en_inst_o", 32'h0, {31'h0, en_inst});
    @(posedge mclk_i) start <= 1'b0;
    idle(4);
    wb(1'b1, 8'h00, 32'h45);
    idle(900);
    @(posedge mclk_i) start <= 1'b1;
    wait_en(1'b1, 20);
    @(posedge mclk_i) start <= 1'b0;
    $display("test start done");
  endtask

  task automatic t_sync();
    wb(1'b1, 8'h00, 32'hc);
    @(posedge mclk_i) {close1, close2} <= 2'b00;
    idle(900);
    @(posedge mclk_i) close1 <= 1'b1;
    idle(300);
    @(posedge mclk_i) close2 <= 1'b1;
    idle(900);
    chk("late_pair", 32'h0, {31'h0, en_inst});
    wb(1'b0, 8'h04, 32'h0);
    chk("sync_missed", 32'h1, {31'h0, rv[9]});
    @(posedge mclk_i) {close1, close2} <= 2'b00;
    idle(900);
    @(posedge mclk_i) {close1, close2} <= 2'b11;
    wait_en(1'b1, 1000);
    wb(1'b1, 8'h00, 32'h7);
    @(posedge mclk_i) {close1, close2} <= 2'b00;
    idle(900);
    @(posedge mclk_i) {close1, close2} <= 2'b11;
    idle(900);
    chk("mode_none", 32'h0, {31'h0, en_inst});
    $display("test sync done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {wb_cyc, wb_stb, wb_we, start, supply_fail, short_c, close1, close2} = '0;
    {wb_adr, wb_dat, mismatches, check_count, cycles} = '0;
    wb_sel = 4'hf;
    feedback = 1'b1;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pulses();
    t_monitored();
    t_auto();
    t_cross();
    t_start();
    t_sync();
    summarize();
  end
endmodule
